// *** rtl/pgpm_pkg.sv ***
// Purpose: constants and types for the port 3 pin mux block
// Assumes: byte-wide register port, one 100 MHz clock
// Notes: register offsets are indices on a 3-bit address
package pgpm_pkg;
  // ==========================================================
  // register map
  localparam logic [2:0] ADDR_OUTPUT_DATA = 3'h0;
  localparam logic [2:0] ADDR_PULLUP_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_DIRECTION = 3'h2;
  localparam logic [2:0] ADDR_MODE_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_PIN_STATUS = 3'h4;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_PULLUP_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_PIN_LEVEL = 8'hFF;
  localparam logic [7:0] RST_PIN_DRIVE = 8'h00;
  localparam logic [7:0] RST_PULLUP_OUT = 8'h00;
  localparam logic RST_CARD_IN = 1'h1;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // ==========================================================
  // pin positions
  localparam int PIN_CARD_CMD_DIR = 4;
  localparam int PIN_CARD_DATA_DIR = 3;
  localparam int PIN_CARD_DATA = 2;
  // ==========================================================
  // mode control register, bit 7 first
  typedef struct packed {
    logic [1:0] spare;
    logic chip_select_count;
    logic direction_signal_enable;
    logic spi_mode;
    logic card_pin_select;
    logic card_interface_enable;
    logic expansion_mode_select;
  } pgpm_mode_type;
  // signals from the card interface
  typedef struct packed {
    logic card_command_direction;
    logic card_chip_select_b;
    logic card_data_direction;
    logic card_chip_select_a;
    logic card_data_out;
    logic card_data_oe;
  } pgpm_card_type;
endpackage

// *** rtl/pgpm_port3.sv ***
// Purpose: eight-bit port with data, pull-up control and pin muxing
// Assumes: registers reached over a plain strobed byte port
// Notes: pin drive and pull-up outputs are registered, one cycle late
//
// Contract
// RULE1 - extended read: data where output, else one
// RULE2 - single-chip read: data where output, else pin
// RULE3 - data register drives general output pins
// RULE4 - pull-up on for input with control set
// RULE5 - extended mode: all pins are data bus
// RULE6 - pins 7 to 5 plain direction-driven io
// RULE7 - wake-up input while mask clear, direction zero; the wake-up path here ignores direction
// RULE8 - card owns 4..2 when enabled, select clear
// RULE9 - pin 4: command direction or chip select b
// RULE10 - pin 3: data direction or chip select a
// RULE11 - pin 2: card data line or receive input
// RULE12 - wake-up input stays available on 4..2
// RULE13 - extended mode pull-ups always off
// RULE14 - pull-ups off in reset, hardware standby
// RULE15 - direction write-only, resets zero, one is output
// RULE16 - pin levels synchronised before read path
// RULE17 - byte-wide registers, bit n is pin n
`timescale 1ns/10ps
module pgpm_port3 (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_o,
  input wire logic hw_standby_i,
  input wire logic [7:0] ext_bus_data_i,
  input wire logic ext_bus_oe_i,
  output logic [7:0] ext_bus_data_o,
  input wire logic [7:0] wakeup_mask_i,
  output logic [7:0] wakeup_input_o,
  input wire pgpm_pkg::pgpm_card_type card_i,
  output logic card_data_in_o
);
  // ==========================================================
  // registers
  logic [7:0] dr_reg, dr_next;
  logic [7:0] pcr_reg, pcr_next;
  logic [7:0] ddr_reg, ddr_next;
  pgpm_pkg::pgpm_mode_type mode_reg, mode_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] sync1_reg, sync2_reg;
  logic [7:0] pin_o_reg, pin_o_next;
  logic [7:0] oe_reg, oe_next;
  logic [7:0] pu_reg, pu_next;
  logic [7:0] wake_reg, wake_next;
  logic card_in_reg, card_in_next;
  logic card_owns;

  // register writes, one byte each
  always_comb begin
    dr_next = dr_reg;
    pcr_next = pcr_reg;
    ddr_next = ddr_reg;
    mode_next = mode_reg;
    if (wr_i) begin
      unique case (addr_i)
        pgpm_pkg::ADDR_OUTPUT_DATA: dr_next = wdata_i; // RULE17
        pgpm_pkg::ADDR_PULLUP_CONTROL: pcr_next = wdata_i; // RULE17
        pgpm_pkg::ADDR_DIRECTION: ddr_next = wdata_i; // RULE15
        pgpm_pkg::ADDR_MODE_CONTROL: begin
          mode_next = pgpm_pkg::pgpm_mode_type'(wdata_i);
          // unused top bits always read back as zero
          mode_next.spare = 2'h0;
        end
        default: begin
        end
      endcase
    end
  end

  // read path; direction reads back as zero
  always_comb begin
    rdata_next = pgpm_pkg::READ_UNMAPPED;
    if (rd_i) begin
      unique case (addr_i)
        pgpm_pkg::ADDR_OUTPUT_DATA: begin
          if (mode_reg.expansion_mode_select)
            rdata_next = (dr_reg & ddr_reg) | ~ddr_reg; // RULE1
          else
            rdata_next = (dr_reg & ddr_reg) | (sync2_reg & ~ddr_reg); // RULE2 RULE16
        end
        pgpm_pkg::ADDR_PULLUP_CONTROL: rdata_next = pcr_reg;
        pgpm_pkg::ADDR_MODE_CONTROL: rdata_next = mode_reg;
        pgpm_pkg::ADDR_PIN_STATUS: rdata_next = sync2_reg;
        default: rdata_next = pgpm_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // pin function mux
  assign card_owns = mode_reg.card_interface_enable & ~mode_reg.card_pin_select; // RULE8

  // card mode with direction outputs enabled
  function automatic logic card_dir_out(input pgpm_pkg::pgpm_mode_type m);
    card_dir_out = !m.spi_mode && m.direction_signal_enable;
  endfunction

  always_comb begin
    pin_o_next = dr_reg; // RULE3
    oe_next = ddr_reg; // RULE6 RULE15
    card_in_next = sync2_reg[pgpm_pkg::PIN_CARD_DATA];
    if (mode_reg.expansion_mode_select) begin
      pin_o_next = ext_bus_data_i; // RULE5
      oe_next = {8{ext_bus_oe_i}}; // RULE5
    end else if (card_owns) begin
      if (card_dir_out(mode_reg)) begin
        pin_o_next[pgpm_pkg::PIN_CARD_CMD_DIR] = card_i.card_command_direction; // RULE9
        oe_next[pgpm_pkg::PIN_CARD_CMD_DIR] = 1'b1; // RULE9
      end else if (mode_reg.spi_mode && mode_reg.chip_select_count) begin
        pin_o_next[pgpm_pkg::PIN_CARD_CMD_DIR] = card_i.card_chip_select_b; // RULE9
        oe_next[pgpm_pkg::PIN_CARD_CMD_DIR] = 1'b1; // RULE9
      end
      if (card_dir_out(mode_reg)) begin
        pin_o_next[pgpm_pkg::PIN_CARD_DATA_DIR] = card_i.card_data_direction; // RULE10
        oe_next[pgpm_pkg::PIN_CARD_DATA_DIR] = 1'b1; // RULE10
      end else if (mode_reg.spi_mode) begin
        pin_o_next[pgpm_pkg::PIN_CARD_DATA_DIR] = card_i.card_chip_select_a; // RULE10
        oe_next[pgpm_pkg::PIN_CARD_DATA_DIR] = 1'b1; // RULE10
      end
      if (!mode_reg.spi_mode) begin
        pin_o_next[pgpm_pkg::PIN_CARD_DATA] = card_i.card_data_out; // RULE11
        oe_next[pgpm_pkg::PIN_CARD_DATA] = card_i.card_data_oe; // RULE11
      end else begin
        pin_o_next[pgpm_pkg::PIN_CARD_DATA] = 1'b0; // RULE11
        oe_next[pgpm_pkg::PIN_CARD_DATA] = 1'b0; // RULE11
      end
    end
    // pull-up only on undriven pins in single-chip mode
    if (mode_reg.expansion_mode_select || hw_standby_i)
      pu_next = 8'h00; // RULE13 RULE14
    else
      pu_next = pcr_reg & ~oe_next; // RULE4
    // active-low wake level passes while mask bit clear
    wake_next = sync2_reg | wakeup_mask_i; // RULE7 RULE12
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dr_reg <= pgpm_pkg::RST_OUTPUT_DATA;
      pcr_reg <= pgpm_pkg::RST_PULLUP_CONTROL;
      ddr_reg <= pgpm_pkg::RST_DIRECTION; // RULE15
      mode_reg <= pgpm_pkg::pgpm_mode_type'(pgpm_pkg::RST_MODE_CONTROL);
      rdata_reg <= pgpm_pkg::READ_UNMAPPED;
      sync1_reg <= pgpm_pkg::RST_PIN_LEVEL;
      sync2_reg <= pgpm_pkg::RST_PIN_LEVEL;
      pin_o_reg <= pgpm_pkg::RST_PIN_DRIVE;
      oe_reg <= pgpm_pkg::RST_PIN_DRIVE;
      pu_reg <= pgpm_pkg::RST_PULLUP_OUT; // RULE14
      wake_reg <= pgpm_pkg::RST_PIN_LEVEL;
      card_in_reg <= pgpm_pkg::RST_CARD_IN;
    end else begin
      dr_reg <= dr_next;
      pcr_reg <= pcr_next;
      ddr_reg <= ddr_next;
      mode_reg <= mode_next;
      rdata_reg <= rdata_next;
      sync1_reg <= pin_i; // RULE16
      sync2_reg <= sync1_reg; // RULE16
      pin_o_reg <= pin_o_next;
      oe_reg <= oe_next;
      pu_reg <= pu_next;
      wake_reg <= wake_next;
      card_in_reg <= card_in_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign pin_o = pin_o_reg;
  assign pin_oe_o = oe_reg;
  assign pullup_o = pu_reg;
  assign ext_bus_data_o = sync2_reg;
  assign wakeup_input_o = wake_reg;
  assign card_data_in_o = card_in_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  chk_ext_read_ones: assert property ( // RULE1
    rd_i && addr_i == pgpm_pkg::ADDR_OUTPUT_DATA && mode_reg.expansion_mode_select
    |=> rdata_o == (($past(dr_reg) & $past(ddr_reg)) | ~$past(ddr_reg)))
    else $error("extended port read wrong");
  chk_single_read_pins: assert property ( // RULE2
    rd_i && addr_i == pgpm_pkg::ADDR_OUTPUT_DATA && !mode_reg.expansion_mode_select
    && !$past(rst_i) && !$past(rst_i, 2)
    |=> rdata_o == (($past(dr_reg) & $past(ddr_reg)) | ($past(pin_i, 3) & ~$past(ddr_reg))))
    else $error("single-chip port read wrong");
  chk_gpio_drive_data: assert property ( // RULE3
    !mode_reg.expansion_mode_select ##1 !$past(mode_reg.expansion_mode_select)
    |-> pin_o[7:5] == $past(dr_reg[7:5]) && pin_oe_o[7:5] == $past(ddr_reg[7:5]))
    else $error("general pins do not follow registers");
  chk_pullup_input: assert property ( // RULE4
    pullup_o != 8'h00 |-> (pullup_o & pin_oe_o) == 8'h00 && !$past(hw_standby_i))
    else $error("pull-up on a driven pin");
  chk_ext_bus_drive: assert property ( // RULE5
    mode_reg.expansion_mode_select && ext_bus_oe_i
    |=> pin_oe_o == 8'hFF && pin_o == $past(ext_bus_data_i))
    else $error("data bus not driven");
  chk_ext_pullup_off: assert property ( // RULE13
    mode_reg.expansion_mode_select |=> pullup_o == 8'h00)
    else $error("pull-up on in extended mode");
  chk_card_csb: assert property ( // RULE9
    !mode_reg.expansion_mode_select && card_owns && mode_reg.spi_mode
    && mode_reg.chip_select_count
    |=> pin_oe_o[4] && pin_o[4] == $past(card_i.card_chip_select_b))
    else $error("chip select b missing");
  chk_card_csa: assert property ( // RULE10
    !mode_reg.expansion_mode_select && card_owns && mode_reg.spi_mode
    |=> pin_oe_o[3] && pin_o[3] == $past(card_i.card_chip_select_a) && !pin_oe_o[2])
    else $error("chip select a or receive input wrong");
  chk_sync_depth: assert property ( // RULE16
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> wakeup_input_o == ($past(pin_i, 3) | $past(wakeup_mask_i)))
    else $error("wake-up level not from synchronised pin");
  chk_dir_write_only: assert property ( // RULE15
    rd_i && addr_i == pgpm_pkg::ADDR_DIRECTION |=> rdata_o == 8'h00)
    else $error("direction register readable");

  // ==========================================================
  // checks: pin function mux
  chk_card_owner: assert property ( // RULE8
    !mode_reg.expansion_mode_select && !card_owns
    |=> pin_oe_o[4:2] == $past(ddr_reg[4:2])
    && pin_o[4:2] == $past(dr_reg[4:2]))
    else $error("pins 4 to 2 not general io");
  chk_card_cmd_dir: assert property ( // RULE9
    !mode_reg.expansion_mode_select && card_owns && !mode_reg.spi_mode
    && mode_reg.direction_signal_enable
    |=> pin_oe_o[4] && pin_o[4] == $past(card_i.card_command_direction))
    else $error("command direction missing");
  chk_card_pin4_gpio: assert property ( // RULE9
    !mode_reg.expansion_mode_select && card_owns && mode_reg.spi_mode
    && !mode_reg.chip_select_count
    |=> pin_oe_o[4] == $past(ddr_reg[4]) && pin_o[4] == $past(dr_reg[4]))
    else $error("pin 4 not general io");
  chk_card_data_dir: assert property ( // RULE10
    !mode_reg.expansion_mode_select && card_owns && !mode_reg.spi_mode
    && mode_reg.direction_signal_enable
    |=> pin_oe_o[3] && pin_o[3] == $past(card_i.card_data_direction))
    else $error("data direction missing");
  chk_card_pin3_gpio: assert property ( // RULE10
    !mode_reg.expansion_mode_select && card_owns && !mode_reg.spi_mode
    && !mode_reg.direction_signal_enable
    |=> pin_oe_o[3] == $past(ddr_reg[3]) && pin_o[3] == $past(dr_reg[3]))
    else $error("pin 3 not general io");
  chk_card_data_line: assert property ( // RULE11
    !mode_reg.expansion_mode_select && card_owns && !mode_reg.spi_mode
    |=> pin_oe_o[2] == $past(card_i.card_data_oe)
    && pin_o[2] == $past(card_i.card_data_out))
    else $error("card data line wrong");
  chk_card_rx_input: assert property ( // RULE11
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> card_data_in_o == $past(pin_i[2], 3))
    else $error("receive input not from pin 2");

  // ==========================================================
  // checks: pull-ups
  chk_pullup_rule: assert property ( // RULE4
    !mode_reg.expansion_mode_select && !hw_standby_i
    |=> pullup_o == ($past(pcr_reg) & ~pin_oe_o))
    else $error("pull-up does not follow control and direction");
  chk_standby_pullup: assert property ( // RULE14
    hw_standby_i |=> pullup_o == 8'h00)
    else $error("pull-up on in hardware standby");
  chk_reset_state: assert property ( // RULE14
    disable iff (1'b0)
    rst_i |=> pullup_o == 8'h00 && pin_oe_o == 8'h00)
    else $error("pins not released in reset");

  // ==========================================================
  // checks: read path and wake-up
  chk_rdata_idle: assert property ( // RULE17
    !rd_i |=> rdata_o == pgpm_pkg::READ_UNMAPPED)
    else $error("read data outside read cycle");
  chk_data_write: assert property ( // RULE17
    wr_i && addr_i == pgpm_pkg::ADDR_OUTPUT_DATA |=> dr_reg == $past(wdata_i))
    else $error("output data write lost");
  chk_wake_masked: assert property ( // RULE7
    wakeup_mask_i != 8'h00 |=> (wakeup_input_o & $past(wakeup_mask_i)) == $past(wakeup_mask_i))
    else $error("masked wake-up input not idle");
  chk_mode_spare: assert property ( // RULE17
    rd_i && addr_i == pgpm_pkg::ADDR_MODE_CONTROL |=> rdata_o[7:6] == 2'h0)
    else $error("unused mode bits read back");

  cov_ext_mode: cover property (mode_reg.expansion_mode_select && ext_bus_oe_i);
  cov_card_mmc: cover property (card_owns && !mode_reg.spi_mode
    && mode_reg.direction_signal_enable);
  cov_card_spi: cover property (card_owns && mode_reg.spi_mode && mode_reg.chip_select_count);
  cov_pullup_on: cover property (pullup_o != 8'h00);
  cov_standby: cover property (hw_standby_i && pcr_reg != 8'h00);
endmodule // pgpm_port3

// *** tb/pgpm_pins_model.sv ***
// Purpose: external pin model for the port 3 block
// Assumes: pin_oe_o high means the block drives the pin
// Notes: undriven pins without pull-up toggle every cycle
`timescale 1ns/10ps
module pgpm_pins_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_o,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_i
);
  // ==========================================================
  // pin resolution
  logic [7:0] float_reg = 8'h55;
  always @(posedge clk_sys_i) begin
    float_reg <= ~float_reg;
  end
  // block drive first, then outside driver, then pull-up
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin_i[n] = pin_oe_o[n] ? pin_o[n] : ext_en_i[n] ? ext_val_i[n] :
                 pullup_o[n] ? 1'b1 : float_reg[n];
    end
  end
endmodule // pgpm_pins_model

// *** tb/pgpm_port3_tb_top.sv ***
// Purpose: register-level bench for the port 3 block
// Assumes: strobed byte register port, pin model on the far side
// Notes: outputs are checked after a few cycles of settling
`timescale 1ns/10ps
module pgpm_port3_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic hw_standby_i = 1'b0;
  logic ext_bus_oe_i = 1'b0;
  logic [7:0] ext_bus_data_i = 8'h00;
  logic [7:0] wakeup_mask_i = 8'h00;
  logic [7:0] ext_val = 8'h3C;
  logic [7:0] ext_en = 8'hFF;
  pgpm_pkg::pgpm_card_type card_i = 6'h00;
  logic [7:0] rdata_o, pin_i, pin_o, pin_oe_o, pullup_o, ext_bus_data_o, wakeup_input_o;
  logic card_data_in_o;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] mt [5] = '{8'h02, 8'h12, 8'h0A, 8'h2A, 8'h16};
  logic [7:0] eo [5] = '{8'h04, 8'h1C, 8'h08, 8'h18, 8'h00};
  logic [7:0] ep [5] = '{8'h04, 8'h14, 8'h08, 8'h08, 8'h00};
  always #5 clk_sys_i = ~clk_sys_i;
  pgpm_port3 i_pgpm_port3 (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .hw_standby_i(hw_standby_i),
    .ext_bus_data_i(ext_bus_data_i), .ext_bus_oe_i(ext_bus_oe_i),
    .ext_bus_data_o(ext_bus_data_o), .wakeup_mask_i(wakeup_mask_i),
    .wakeup_input_o(wakeup_input_o), .card_i(card_i), .card_data_in_o(card_data_in_o));
  pgpm_pins_model i_pgpm_pins_model (.clk_sys_i(clk_sys_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .pin_i(pin_i));
  // ==========================================================
  // access and check tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, rdata_o, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    settle();
    chk("pullup", pullup_o, 8'h00);
    chk("wake", wakeup_input_o, 8'h3C);
    rd(pgpm_pkg::ADDR_OUTPUT_DATA, 8'h3C, "port");
    rd(pgpm_pkg::ADDR_PULLUP_CONTROL, 8'h00, "pup");
    rd(3'h5, 8'h00, "unmapped");
    wr(pgpm_pkg::ADDR_OUTPUT_DATA, 8'hA5);
    wr(pgpm_pkg::ADDR_DIRECTION, 8'hF0);
    settle();
    chk("oe", pin_oe_o, 8'hF0);
    chk("drive", pin_o & 8'hF0, 8'hA0);
    rd(pgpm_pkg::ADDR_OUTPUT_DATA, 8'hAC, "port");
    rd(pgpm_pkg::ADDR_DIRECTION, 8'h00, "dir");
    wakeup_mask_i <= 8'h0F;
    wr(pgpm_pkg::ADDR_DIRECTION, 8'h00);
    settle();
    chk("wake", wakeup_input_o, 8'h3F);
    wr(pgpm_pkg::ADDR_DIRECTION, 8'hF0);
    wr(pgpm_pkg::ADDR_PULLUP_CONTROL, 8'hFF);
    ext_en <= 8'h00;
    settle();
    chk("pullup", pullup_o, 8'h0F);
    rd(pgpm_pkg::ADDR_OUTPUT_DATA, 8'hAF, "port");
    @(posedge clk_sys_i);
    hw_standby_i <= 1'b1;
    settle();
    chk("pullup", pullup_o, 8'h00);
    @(posedge clk_sys_i);
    hw_standby_i <= 1'b0;
    ext_en <= 8'hFF;
    wr(pgpm_pkg::ADDR_MODE_CONTROL, 8'h01);
    settle();
    chk("pullup", pullup_o, 8'h00);
    rd(pgpm_pkg::ADDR_OUTPUT_DATA, 8'hAF, "port");
    @(posedge clk_sys_i);
    ext_bus_oe_i <= 1'b1;
    ext_bus_data_i <= 8'h5A;
    settle();
    chk("oe", pin_oe_o, 8'hFF);
    chk("drive", pin_o, 8'h5A);
    chk("bus", ext_bus_data_o, 8'h5A);
    @(posedge clk_sys_i);
    ext_bus_oe_i <= 1'b0;
    card_i <= 6'h27;
    wr(pgpm_pkg::ADDR_DIRECTION, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(pgpm_pkg::ADDR_MODE_CONTROL, mt[i]);
      settle();
      chk("card oe", pin_oe_o & 8'hFC, eo[i]);
      chk("card out", pin_o & pin_oe_o & 8'hFC, ep[i]);
    end
    wr(pgpm_pkg::ADDR_MODE_CONTROL, 8'hEA);
    settle();
    rd(pgpm_pkg::ADDR_MODE_CONTROL, 8'h2A, "mode");
    rd(pgpm_pkg::ADDR_PIN_STATUS, 8'h2C, "status");
    chk("rx", {7'h00, card_data_in_o}, 8'h01);
    chk("wake", wakeup_input_o & 8'h1C, 8'h0C);
    ext_val <= 8'h38;
    settle();
    chk("rx", {7'h00, card_data_in_o}, 8'h00);
    end_of_test();
  end
endmodule // pgpm_port3_tb_top
